//--- rtl/dioc_pkg.sv
// constants, types and field layout for the digital io channel conditioning block
// Summary of operation
// - every one of the sixteen channels keeps its own restart mode, overload level, filter time and polarity.
// - in automatic mode an overload or short switches the output off and a fixed delay later it is tried again.
// - in reset-required mode an output tripped by an overload or short stays off and never turns itself on.
// - after reset every channel restarts automatically after a failure.
// - the overload level is 0.5 A, 1.0 A, 1.5 A, 2.0 A or maximum and sets where the overload diagnostic is raised.
// - with the maximum option current limiting is off and the full output current is allowed.
// - after reset every channel's overload setting is the maximum option.
// - the input filter is off or 1, 2, 3, 6, 10 or 15 ms per channel.
// - normally-open polarity reports the input level unchanged, a low input reads as zero.
// - normally-closed polarity inverts the filtered input, a high input reads as zero.
// - the channel indicator always shows the physical input level whatever the polarity.
// - after reset every channel's polarity is normally-open.
package dioc_pkg;
  localparam int NCH = 16;
  localparam int CLK_HZ = 100000000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int RETRY_MS = 100;
  localparam int CNT_W = 32;

  // register map, byte addresses
  localparam int AW = 8;
  localparam logic [7:0] OFS_OUT_CMD = 8'h00;
  localparam logic [7:0] OFS_RESTART_MODE = 8'h04;
  localparam logic [7:0] OFS_LIMIT_LO = 8'h08;
  localparam logic [7:0] OFS_LIMIT_HI = 8'h0c;
  localparam logic [7:0] OFS_FILTER_LO = 8'h10;
  localparam logic [7:0] OFS_FILTER_HI = 8'h14;
  localparam logic [7:0] OFS_POLARITY = 8'h18;
  localparam logic [7:0] OFS_IN_STATE = 8'h1c;
  localparam logic [7:0] OFS_OUT_STATE = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h28;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h2c;

  // nibble-per-channel settings, eight channels per word
  localparam int FLD_W = 4;
  localparam int SEL_W = 3;
  localparam int HALF = NCH / 2;
  localparam logic [31:0] NIB_MASK = 32'h77777777;

  localparam logic [SEL_W-1:0] LIM_0A5 = 3'h0;
  localparam logic [SEL_W-1:0] LIM_1A0 = 3'h1;
  localparam logic [SEL_W-1:0] LIM_1A5 = 3'h2;
  localparam logic [SEL_W-1:0] LIM_2A0 = 3'h3;
  localparam logic [SEL_W-1:0] LIM_MAX = 3'h4;

  localparam logic [SEL_W-1:0] FILT_OFF = 3'h0;
  localparam logic [SEL_W-1:0] FILT_1MS = 3'h1;
  localparam logic [SEL_W-1:0] FILT_2MS = 3'h2;
  localparam logic [SEL_W-1:0] FILT_3MS = 3'h3;
  localparam logic [SEL_W-1:0] FILT_6MS = 3'h4;
  localparam logic [SEL_W-1:0] FILT_10MS = 3'h5;
  localparam logic [SEL_W-1:0] FILT_15MS = 3'h6;

  localparam int MS_1 = 1;
  localparam int MS_2 = 2;
  localparam int MS_3 = 3;
  localparam int MS_6 = 6;
  localparam int MS_10 = 10;
  localparam int MS_15 = 15;

  localparam logic [NCH-1:0] RST_RESTART_MODE = 16'h0000;
  localparam logic [31:0] RST_LIMIT = 32'h44444444;
  localparam logic [31:0] RST_FILTER = 32'h33333333;
  localparam logic [NCH-1:0] RST_POLARITY = 16'h0000;

  // measured current band from the output stage, band k means at least threshold k
  localparam int BAND_W = 3;

  typedef enum logic [1:0] {
    DIOC_IDLE = 2'b00,
    DIOC_ON = 2'b01,
    DIOC_RETRY = 2'b11,
    DIOC_LOCK = 2'b10
  } dioc_out_state_t;

  // filter code to milliseconds, unknown codes take the longest time
  function automatic int filt_ms(input logic [SEL_W-1:0] code);
    case (code)
      FILT_OFF: filt_ms = 0;
      FILT_1MS: filt_ms = MS_1;
      FILT_2MS: filt_ms = MS_2;
      FILT_3MS: filt_ms = MS_3;
      FILT_6MS: filt_ms = MS_6;
      FILT_10MS: filt_ms = MS_10;
      default: filt_ms = MS_15;
    endcase
  endfunction
endpackage

//--- rtl/dioc_in_filter.sv
// one input channel debounce filter
`timescale 1ns/100ps
module dioc_in_filter #(
  parameter int CNT_W = dioc_pkg::CNT_W
) (
  input wire logic clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic raw, // synchronised input level
  input wire logic [CNT_W-1:0] hold_cyc, // cycles a new level must hold, zero bypasses
  output logic filt // filtered level
);
  logic [CNT_W-1:0] cnt;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt <= '0;
      filt <= 1'b0;
    end else if (hold_cyc == '0) begin
      cnt <= '0;
      filt <= raw;
    end else if (raw == filt) begin
      cnt <= '0; // any bounce back restarts the hold time
    end else if (cnt + 1'b1 >= hold_cyc) begin
      cnt <= '0;
      filt <= raw;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule

//--- rtl/dioc_out_guard.sv
// one output channel overload guard with restart handling
`timescale 1ns/100ps
module dioc_out_guard #(
  parameter int CNT_W = dioc_pkg::CNT_W,
  parameter int RETRY_CYC = dioc_pkg::RETRY_MS * dioc_pkg::CYC_PER_MS
) (
  input wire logic clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic cmd, // output control bit from the controller
  input wire logic latch_mode, // 1 waits for a controller reset after a trip
  input wire logic fault, // overload or short seen while driving
  output logic drive, // output switch on
  output logic locked, // tripped and waiting for cmd low
  output logic trip // one-cycle pulse on each trip
);
  localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_CYC - 1);

  dioc_pkg::dioc_out_state_t state;
  logic [CNT_W-1:0] wait_cnt;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= dioc_pkg::DIOC_IDLE;
      trip <= 1'b0;
    end else begin
      trip <= 1'b0;
      unique case (state)
        dioc_pkg::DIOC_IDLE: if (cmd) state <= dioc_pkg::DIOC_ON;
        dioc_pkg::DIOC_ON: begin
          if (!cmd) begin
            state <= dioc_pkg::DIOC_IDLE;
          end else if (fault) begin
            trip <= 1'b1;
            state <= latch_mode ? dioc_pkg::DIOC_LOCK : dioc_pkg::DIOC_RETRY;
          end
        end
        dioc_pkg::DIOC_RETRY: begin
          if (!cmd) state <= dioc_pkg::DIOC_IDLE;
          else if (wait_cnt == RETRY_LAST) state <= dioc_pkg::DIOC_ON;
        end
        dioc_pkg::DIOC_LOCK: if (!cmd) state <= dioc_pkg::DIOC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || state != dioc_pkg::DIOC_RETRY) wait_cnt <= '0;
    else wait_cnt <= wait_cnt + 1'b1;
  end

  assign drive = (state == dioc_pkg::DIOC_ON);
  assign locked = (state == dioc_pkg::DIOC_LOCK);
endmodule

//--- rtl/dioc_top.sv
// sixteen channel digital io conditioning with register port
`timescale 1ns/100ps
module dioc_top #(
  parameter int CYC_PER_MS = dioc_pkg::CYC_PER_MS,
  parameter int RETRY_CYC = dioc_pkg::RETRY_MS * dioc_pkg::CYC_PER_MS
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic [dioc_pkg::AW-1:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic [dioc_pkg::NCH-1:0] din, // raw input pins
  input wire logic [dioc_pkg::NCH-1:0] short_det, // short circuit sense per output
  input wire logic [dioc_pkg::NCH*dioc_pkg::BAND_W-1:0] cur_band, // measured current band per output
  output logic [dioc_pkg::NCH-1:0] dout, // output switch drive
  output logic [dioc_pkg::NCH-1:0] limit_en, // current limiting active per output
  output logic [dioc_pkg::NCH-1:0] led, // channel indicators
  output logic irq // level interrupt
);
  localparam int NCH = dioc_pkg::NCH;
  localparam int CW = dioc_pkg::CNT_W;
  localparam int BW = dioc_pkg::BAND_W;
  localparam int SW = dioc_pkg::SEL_W;
  localparam int FW = dioc_pkg::FLD_W;
  localparam int HALF = dioc_pkg::HALF;

  // software settings
  logic [NCH-1:0] out_cmd;
  logic [NCH-1:0] latch_mode;
  logic [63:0] limit_cfg;
  logic [63:0] filter_cfg;
  logic [NCH-1:0] polarity;
  logic [NCH-1:0] irq_status;
  logic [NCH-1:0] irq_enable;

  // pin synchronisers
  logic [NCH-1:0] din_meta;
  logic [NCH-1:0] din_sync;
  logic [NCH-1:0] short_meta;
  logic [NCH-1:0] short_sync;
  logic [NCH*BW-1:0] band_meta;
  logic [NCH*BW-1:0] band_sync;

  logic [NCH-1:0] filt;
  logic [NCH-1:0] in_state;
  logic [NCH-1:0] drive;
  logic [NCH-1:0] locked;
  logic [NCH-1:0] trip;
  logic [NCH-1:0] fault;
  logic [NCH-1:0] next_irq_status;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      din_meta <= '0;
      din_sync <= '0;
      short_meta <= '0;
      short_sync <= '0;
      band_meta <= '0;
      band_sync <= '0;
    end else begin
      din_meta <= din;
      din_sync <= din_meta;
      short_meta <= short_det;
      short_sync <= short_meta;
      band_meta <= cur_band;
      band_sync <= band_meta;
    end
  end

  // register writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_cmd <= '0;
      latch_mode <= dioc_pkg::RST_RESTART_MODE;
      limit_cfg <= {dioc_pkg::RST_LIMIT, dioc_pkg::RST_LIMIT};
      filter_cfg <= {dioc_pkg::RST_FILTER, dioc_pkg::RST_FILTER};
      polarity <= dioc_pkg::RST_POLARITY;
      irq_enable <= '0;
    end else if (wr) begin
      unique case (addr)
        dioc_pkg::OFS_OUT_CMD: out_cmd <= wdata[NCH-1:0];
        dioc_pkg::OFS_RESTART_MODE: latch_mode <= wdata[NCH-1:0];
        dioc_pkg::OFS_LIMIT_LO: limit_cfg[31:0] <= wdata & dioc_pkg::NIB_MASK;
        dioc_pkg::OFS_LIMIT_HI: limit_cfg[63:32] <= wdata & dioc_pkg::NIB_MASK;
        dioc_pkg::OFS_FILTER_LO: filter_cfg[31:0] <= wdata & dioc_pkg::NIB_MASK;
        dioc_pkg::OFS_FILTER_HI: filter_cfg[63:32] <= wdata & dioc_pkg::NIB_MASK;
        dioc_pkg::OFS_POLARITY: polarity <= wdata[NCH-1:0];
        dioc_pkg::OFS_IRQ_ENABLE: irq_enable <= wdata[NCH-1:0];
        default: ;
      endcase
    end
  end

  // per channel datapath
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [SW-1:0] lim;
    logic [SW-1:0] fsel;
    logic [BW-1:0] band;
    logic [CW-1:0] hold_cyc;

    assign lim = limit_cfg[i*FW +: SW];
    assign fsel = filter_cfg[i*FW +: SW];
    assign band = band_sync[i*BW +: BW];
    assign hold_cyc = CW'(dioc_pkg::filt_ms(fsel) * CYC_PER_MS);

    // band above the chosen level raises overload; max only reacts to a short
    assign fault[i] = short_sync[i] | ((lim < dioc_pkg::LIM_MAX) && (band > lim));

    dioc_in_filter #(
      .CNT_W(CW)
    ) u_filt (
      .clk(clk),
      .rstn(rstn),
      .raw(din_sync[i]),
      .hold_cyc(hold_cyc),
      .filt(filt[i])
    );

    dioc_out_guard #(
      .CNT_W(CW),
      .RETRY_CYC(RETRY_CYC)
    ) u_guard (
      .clk(clk),
      .rstn(rstn),
      .cmd(out_cmd[i]),
      .latch_mode(latch_mode[i]),
      .fault(fault[i]),
      .drive(drive[i]),
      .locked(locked[i]),
      .trip(trip[i])
    );
  end

  // pin side outputs, all registered
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dout <= '0;
      limit_en <= '0;
      led <= '0;
      in_state <= '0;
    end else begin
      dout <= drive;
      for (int i = 0; i < NCH; i++) begin
        limit_en[i] <= (limit_cfg[i*FW +: SW] < dioc_pkg::LIM_MAX);
      end
      led <= din_sync;
      in_state <= filt ^ polarity;
    end
  end

  // sticky trip flags, a trip in the clearing cycle survives
  always_comb begin
    next_irq_status = irq_status | trip;
    if (wr && addr == dioc_pkg::OFS_IRQ_CLEAR) begin
      next_irq_status = (irq_status & ~wdata[NCH-1:0]) | trip;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_enable);
    end
  end

  // register reads, answer one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        dioc_pkg::OFS_OUT_CMD: rdata <= {16'h0000, out_cmd};
        dioc_pkg::OFS_RESTART_MODE: rdata <= {16'h0000, latch_mode};
        dioc_pkg::OFS_LIMIT_LO: rdata <= limit_cfg[31:0];
        dioc_pkg::OFS_LIMIT_HI: rdata <= limit_cfg[63:32];
        dioc_pkg::OFS_FILTER_LO: rdata <= filter_cfg[31:0];
        dioc_pkg::OFS_FILTER_HI: rdata <= filter_cfg[63:32];
        dioc_pkg::OFS_POLARITY: rdata <= {16'h0000, polarity};
        dioc_pkg::OFS_IN_STATE: rdata <= {16'h0000, in_state};
        dioc_pkg::OFS_OUT_STATE: rdata <= {locked, dout};
        dioc_pkg::OFS_IRQ_STATUS: rdata <= {16'h0000, irq_status};
        dioc_pkg::OFS_IRQ_ENABLE: rdata <= {16'h0000, irq_enable};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule

//--- testbench/dioc_top_asserts.sv
// port assertions for the conditioning block
`timescale 1ns/100ps
module dioc_top_asserts (
  input wire logic clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [31:0] rdata, // read data
  input wire logic [15:0] din, // raw inputs
  input wire logic [15:0] short_det, // short sense
  input wire logic [15:0] dout, // switch drive
  input wire logic [15:0] limit_en, // limiting active
  input wire logic [15:0] led, // indicators
  input wire logic irq // interrupt
);
  logic [2:0] up;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // synchronisers hold stale samples for a few cycles after reset
  always_ff @(posedge clk) begin
    if (!rstn) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  property p_rd_idle;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
  property p_rst_out;
    !$past(rstn) |-> dout == 16'h0 && limit_en == 16'h0 && !irq;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  property p_led;
    up == 3'h7 |-> led == $past(din, 3);
  endproperty
  a_led: assert property (p_led) else $error("indicator not following pin");
  property p_short_off;
    (short_det[0] && dout[0]) |-> ##[1:5] !dout[0];
  endproperty
  a_short_off: assert property (p_short_off) else $error("output kept on into a short");
  property p_retry_gap;
    $fell(dout[0]) && $past(short_det[0], 2) |-> !dout[0] [*8];
  endproperty
  a_retry_gap: assert property (p_retry_gap) else $error("retry came too soon");
  property p_irq_rise;
    $rose(irq) |-> $past(wr) || $past(wr, 2) || (($past(dout) & ~dout) != 16'h0);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt without trip");
  property p_irq_fall;
    $fell(irq) |-> $past(wr) || $past(wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped by itself");
  property p_lim_hold;
    !$past(wr) && !$past(wr, 2) |-> $stable(limit_en);
  endproperty
  a_lim_hold: assert property (p_lim_hold) else $error("limit enable moved without write");
endmodule
bind dioc_top dioc_top_asserts dioc_top_asserts_inst (.clk(clk), .rstn(rstn), .wr(wr), .rd(rd), .rdata(rdata),
  .din(din), .short_det(short_det), .dout(dout), .limit_en(limit_en), .led(led), .irq(irq));

//--- testbench/dioc_load_model.sv
// output load model: current and short sense seen by the switches
`timescale 1ns/100ps
module dioc_load_model (
  input wire logic [15:0] dout, // switch drive
  input wire logic [15:0] short_req, // loads to short
  input wire logic [2:0] band, // load band when driven
  output logic [15:0] short_det, // short sense
  output logic [47:0] cur_band // band per channel
);
  // a switched-off load draws nothing, so sense drops to zero
  assign short_det = dout & short_req;
  always_comb begin
    for (int i = 0; i < 16; i++) cur_band[3*i +: 3] = dout[i] ? band : 3'h0;
  end
endmodule

//--- testbench/tb_dioc_top.sv
// self-checking bench for the conditioning block
`timescale 1ns/100ps
module tb_dioc_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] din = 16'h0;
  logic [15:0] short_req = 16'h0;
  logic [2:0] band = 3'h0;
  logic [31:0] rdata, v, seed;
  logic [15:0] short_det, dout, limit_en, led;
  logic [47:0] cur_band;
  logic irq;
  logic [7:0] regs[7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h2c};
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  dioc_top #(.CYC_PER_MS(10), .RETRY_CYC(20)) dioc_top_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .din(din), .short_det(short_det), .cur_band(cur_band), .dout(dout),
    .limit_en(limit_en), .led(led), .irq(irq));
  dioc_load_model dioc_load_model_inst (.dout(dout), .short_req(short_req), .band(band), .short_det(short_det),
    .cur_band(cur_band));
  function automatic int fms(input int c);
    int t[7] = '{0, 1, 2, 3, 6, 10, 15};
    return t[c];
  endfunction
  function automatic logic [31:0] rmask(input logic [7:0] a);
    return (a == 8'h04 || a == 8'h18 || a == 8'h2c) ? 32'hffff : 32'h77777777;
  endfunction
  // reset value of each setting, so later tests start from the documented defaults
  function automatic logic [31:0] rdef(input logic [7:0] a);
    if (a == 8'h08 || a == 8'h0c) return 32'h44444444;
    if (a == 8'h10 || a == 8'h14) return 32'h33333333;
    return 32'h0;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
    tick(1);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    tick(1);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    tick(1);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      report_and_stop;
    end
  end
  initial begin
    seed = 32'h1b90;
    tick(20);
    rstn <= 1'b1;
    tick(1);
    rreg(8'h04, 32'h0);
    rreg(8'h08, 32'h44444444);
    rreg(8'h0c, 32'h44444444);
    rreg(8'h10, 32'h33333333);
    rreg(8'h14, 32'h33333333);
    rreg(8'h18, 32'h0);
    rreg(8'h30, 32'h0);
    foreach (regs[i]) begin
      v = $random(seed);
      wreg(regs[i], v);
      rreg(regs[i], v & rmask(regs[i]));
      wreg(regs[i], rdef(regs[i]));
    end
    $display("test settings done");
    for (int c = 0; c < 7; c++) begin
      wreg(8'h10, {8{c[3:0]}});
      din <= 16'h00ff;
      if (c > 0) begin
        tick(fms(c) * 10 - 2);
        rreg(8'h1c, 32'h0);
      end
      tick(12);
      rreg(8'h1c, 32'h00ff);
      din <= 16'h0;
      tick(fms(c) * 10 + 12);
    end
    $display("test filter done");
    wreg(8'h10, 32'h0);
    wreg(8'h14, 32'h0);
    for (int i = 0; i < 5; i++) begin
      v = i == 0 ? 32'hffff0000 : $random(seed);
      din <= v[15:0];
      wreg(8'h18, {16'h0, v[31:16]});
      tick(4);
      chk({16'h0, led}, {16'h0, v[15:0]});
      rreg(8'h1c, {16'h0, v[15:0] ^ v[31:16]});
    end
    $display("test polarity done");
    wreg(8'h00, 32'hffff);
    tick(3);
    chk({16'h0, dout}, 32'hffff);
    for (int k = 0; k < 5; k++) begin
      wreg(8'h08, {8{k[3:0]}});
      wreg(8'h0c, {8{k[3:0]}});
      tick(1);
      chk({16'h0, limit_en}, k < 4 ? 32'hffff : 32'h0);
      band <= k[2:0];
      tick(8);
      rreg(8'h24, 32'h0);
      band <= k < 4 ? k[2:0] + 3'h1 : 3'h4;
      tick(8);
      rreg(8'h24, k < 4 ? 32'hffff : 32'h0);
      band <= 3'h0;
      wreg(8'h28, 32'hffff);
      tick(25);
    end
    $display("test limits done");
    wreg(8'h2c, 32'h1);
    short_req <= 16'h0001;
    tick(6);
    chk({31'h0, irq}, 32'h1);
    chk({16'h0, dout}, 32'hfffe);
    wreg(8'h28, 32'h1);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    tick(25);
    rreg(8'h24, 32'h1);
    wreg(8'h2c, 32'h0);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    short_req <= 16'h0;
    tick(30);
    chk({16'h0, dout}, 32'hffff);
    $display("test auto restart done");
    wreg(8'h04, 32'h1);
    short_req <= 16'h0001;
    tick(6);
    short_req <= 16'h0;
    tick(40);
    rreg(8'h20, 32'h0001fffe);
    wreg(8'h00, 32'hfffe);
    wreg(8'h00, 32'hffff);
    tick(3);
    chk({16'h0, dout}, 32'hffff);
    $display("test latched restart done");
    report_and_stop;
  end
endmodule
